// file: common/oid_pkg.sv
// Purpose: Types for the operand instruction decoder
// Assumes: Used with oid_regs.svh constants
// Notes: Nothing is imported; users write oid_pkg::name
package oid_pkg;
  typedef enum logic [3:0] {
    CL_SINGLE = 4'h0,
    CL_DOUBLE = 4'h1,
    CL_BRREG = 4'h2,
    CL_BRIND = 4'h3,
    CL_SVI = 4'h4,
    CL_SHIFT = 4'h5,
    CL_GENERIC = 4'h6,
    CL_IO = 4'h7,
    CL_SCI = 4'h8
  } oid_class_e;
  typedef enum logic [3:0] {
    AM_REG = 4'h0,
    AM_IMM = 4'h1,
    AM_ABS = 4'h2,
    AM_BASE = 4'h3,
    AM_PUSH = 4'h4,
    AM_POP = 4'h5,
    AM_AIX_DEC = 4'h6,
    AM_AIX_INC = 4'h7,
    AM_REL_P = 4'h8,
    AM_REL_B = 4'h9,
    AM_REL_IV = 4'ha,
    AM_NONE = 4'hb
  } oid_mode_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXT = 2'h1
  } oid_state_e;
  typedef struct packed {
    oid_class_e cls;
    oid_mode_e mode;
    logic [4:0] opcode;
    logic [2:0] regNum;
    logic regIsAddr;
    logic indirect;
    logic indexed;
    logic [1:0] indexReg;
    logic [2:0] baseReg;
    logic [2:0] length;
  } oid_dec_s;
  typedef struct packed {
    logic [15:0] effAddr;
    logic [15:0] operand;
    logic [15:0] newBase;
    logic [15:0] newIndex;
    logic writeBase;
    logic writeIndex;
    logic [15:0] nextPc;
    logic [5:0] trapVector;
    logic branchTaken;
    logic clearTarget;
    logic addToReg;
    logic rotatePair;
  } oid_res_s;
endpackage

// file: common/oid_regs.svh
// Purpose: Named constants for the operand instruction decoder
// Assumes: Bit 15 of the instruction is the most significant bit
// Notes: Syllable and opcode code points are local choices
`ifndef OID_REGS_SVH
`define OID_REGS_SVH
`define OID_W_OPBIT 15
`define OID_RN_HI 14
`define OID_RN_LO 12
`define OID_OP_HI 11
`define OID_OP_LO 7
`define OID_AS_HI 6
`define OID_AS_LO 0
`define OID_RN_ZERO 3'h0
`define OID_OPC_ZERO 4'h0
`define OID_TOP8_ZERO 8'h00
`define OID_LEN_ONE 3'h1
`define OID_LEN_TWO 3'h2
`define OID_LEN_IOMIN 3'h3
`define OID_LEN_IOMAX 3'h6
`define OID_STEP_ONE 16'h0001
`define OID_STEP_TWO 16'h0002
`define OID_TRAP_NONE 6'h00
`define OID_TRAP_MCALL 6'h01
`define OID_TRAP_SCI 6'h03
`define OID_FN_MCALL 8'h01
`define OID_OP_CLEAR 5'h01
`define OID_OP_ADD 5'h02
`define OID_OP_ADDR_REG 5'h10
`define OID_OP_DBLWORD 5'h18
`define OID_OP_SCI_HI 2'h3
`define OID_OP_IO_LOAD_OP 5'h02
`define OID_IO_PREFIX 4'h8
`define OID_IO_SEL 3'h0
`define OID_SHF_ROTL 3'h1
`define OID_DBL_BIT 7
`define OID_WRAP16 16'hffff
`endif

// file: testbench/oid_mem_model.sv
// Purpose: Memory side model feeding extension words to the decoder
// Assumes: The bench loads the words before each instruction
// Notes: Idle data shows an inverted word, never the last value
module oid_mem_model (
  input wire logic core_clk,
  input wire logic load,
  input wire logic clkEn,
  input wire logic needExt,
  output logic extValid,
  output logic [15:0] extWord
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] words [0:5];
  int taken = 0;

  // ----------------------------------------
  // One word per cycle while the decoder waits
  // ----------------------------------------
  assign extValid = needExt && taken < 6;
  assign extWord = extValid ? words[taken] : ~words[0];

  always @(posedge core_clk) begin
    if (load)
      taken <= 0;
    else if (clkEn && extValid)
      taken <= taken + 1;
  end
endmodule

// file: testbench/tb.sv
// Purpose: Self-checking bench for the operand instruction decoder
// Assumes: Memory model supplies extension words on demand
// Notes: Register values random, wrap boundaries mixed in
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0;
  logic nrst = 0;
  logic clkEn = 0;
  logic instValid = 0;
  logic load = 0;
  logic regCondTrue = 0;
  logic indicatorTrue = 0;
  logic [15:0] instWord = 16'h0000;
  logic [15:0] pcIn = 16'h0000;
  logic [15:0] baseVal = 16'h0000;
  logic [15:0] indexVal = 16'h0000;
  logic [15:0] levelVectorBase = 16'h0000;
  logic [15:0] p, b, x, v, extWord;
  logic [15:0] ev;
  logic extValid, resValid, needExt;
  logic [2:0] rn, kd, r;
  oid_pkg::oid_dec_s decOut;
  oid_pkg::oid_res_s resOut;
  logic [4:0] ops [0:3] = '{5'h01, 5'h02, 5'h10, 5'h18};
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 40867;
  int n, i;

  always #2.5 core_clk = ~core_clk;

  operand_instruction_decode i_dut (.core_clk(core_clk), .nrst(nrst),
    .clkEn(clkEn), .instValid(instValid), .instWord(instWord),
    .extValid(extValid), .extWord(extWord), .pcIn(pcIn),
    .baseVal(baseVal), .indexVal(indexVal),
    .levelVectorBase(levelVectorBase), .regCondTrue(regCondTrue),
    .indicatorTrue(indicatorTrue), .decOut(decOut), .resOut(resOut),
    .resValid(resValid), .needExt(needExt));

  oid_mem_model i_mem (.core_clk(core_clk), .load(load), .clkEn(clkEn),
    .needExt(needExt), .extValid(extValid), .extWord(extWord));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic summarize();
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Hold keeps instValid up for the first cycle after acceptance; it must be ignored
  task automatic issue(logic [15:0] w, logic [15:0] e, logic hold);
    int k;
    logic done;
    done = 0;
    for (k = 0; k < 6; k++)
      i_mem.words[k] = k ? 16'($random(seed)) : e;
    p = ($random(seed) & 3) ? 16'($random(seed)) : 16'hffff;
    b = ($random(seed) & 3) ? 16'($random(seed)) : 16'h0000;
    x = ($random(seed) & 3) ? 16'($random(seed)) : 16'hffff;
    v = 16'($random(seed));
    @(posedge core_clk);
    instWord <= w;
    instValid <= 1;
    load <= 1;
    pcIn <= p;
    baseVal <= b;
    indexVal <= x;
    levelVectorBase <= v;
    regCondTrue <= 1'($random(seed));
    indicatorTrue <= 1'($random(seed));
    @(posedge core_clk);
    load <= 0;
    instValid <= hold;
    for (k = 0; k < 20 && !done; k++) begin
      #1;
      if (resValid === 1'b1)
        done = 1;
      else begin
        @(posedge core_clk);
        instValid <= 0;
      end
    end
    chk("resValid", 1, done);
    n = 1 + i_mem.taken;
    repeat (2) begin
      @(posedge core_clk);
      instValid <= 0;
      #1;
      chk("resValid pulse", 0, resValid);
    end
  endtask

  task automatic op_case(logic [2:0] rn, logic [4:0] op, logic [2:0] kd,
                         logic [2:0] r);
    logic [15:0] e, ea, nb, ni, st;
    logic [3:0] m, c;
    logic sci;
    int len;
    e = 16'($random(seed));
    sci = op[4:3] == 2'h3;
    st = (op == 5'h18) ? 16'h0002 : 16'h0001;
    len = (kd > 5 || (kd < 2 && r == 0)) ? 2 : 1;
    issue({1'b1, rn, op, kd, 1'($random(seed)), r}, e,
          len == 2 && 1'($random(seed)));
    c = sci ? oid_pkg::CL_SCI : rn ? oid_pkg::CL_DOUBLE : oid_pkg::CL_SINGLE;
    nb = b;
    ni = x;
    ea = b;
    case (kd)
      3'h0: m = r ? oid_pkg::AM_REG : oid_pkg::AM_IMM;
      3'h1: begin
        m = r ? oid_pkg::AM_BASE : oid_pkg::AM_ABS;
        if (r == 0)
          ea = e;
      end
      3'h2: begin
        m = oid_pkg::AM_PUSH;
        ea = b - st;
        nb = ea;
      end
      3'h3: begin
        m = oid_pkg::AM_POP;
        nb = b + st;
      end
      3'h4: begin
        m = oid_pkg::AM_AIX_DEC;
        ni = x - 16'h0001;
        ea = b + ni;
      end
      3'h5: begin
        m = oid_pkg::AM_AIX_INC;
        ni = x + 16'h0001;
        ea = b + x;
      end
      3'h6: begin
        m = r ? oid_pkg::AM_REL_B : oid_pkg::AM_REL_P;
        ea = (r ? b : p) + e;
      end
      default: begin
        m = oid_pkg::AM_REL_IV;
        ea = v + e;
      end
    endcase
    chk("words", 16'(len), 16'(n));
    chk("nextPc", p + 16'(len), resOut.nextPc);
    chk("mode", m, decOut.mode);
    chk("opcode", op, decOut.opcode);
    chk("regNum", rn, decOut.regNum);
    chk("class", c, decOut.cls);
    chk("regIsAddr", rn != 0 && op >= 5'h10, decOut.regIsAddr);
    chk("trap", sci ? 6'h03 : 6'h00, resOut.trapVector);
    chk("clear", rn == 0 && op == 5'h01, resOut.clearTarget);
    chk("add", rn != 0 && op == 5'h02, resOut.addToReg);
    if (kd == 0 && r == 0)
      chk("operand", e, resOut.operand);
    if (kd != 0)
      chk("effAddr", ea, resOut.effAddr);
    if (kd == 2 || kd == 3)
      chk("newBase", nb, resOut.newBase);
    if (kd == 4 || kd == 5)
      chk("newIndex", ni, resOut.newIndex);
    if (kd == 7)
      chk("indirect", 0, decOut.indirect);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1;
    repeat (6) @(posedge core_clk);
    instWord <= 16'h8081;
    instValid <= 1;
    repeat (3) begin
      @(posedge core_clk);
      #1;
      chk("frozen resValid", 0, resValid);
    end
    @(posedge core_clk);
    instValid <= 0;
    clkEn <= 1;
    for (i = 0; i < 64; i++) begin
      rn = 3'($random(seed));
      if ((i / 2) % 4 == 1 && rn == 0)
        rn = 3'h5;
      kd = 3'(i / 8);
      r = (i[0] || (kd > 1 && kd < 6)) ? 3'(i % 3 + 1) : 3'h0;
      op_case(rn, ops[(i / 2) % 4], kd, r);
    end
    issue(16'h0001, 16'h0000, 0);
    chk("class", oid_pkg::CL_GENERIC, decOut.cls);
    chk("trap", 6'h01, resOut.trapVector);
    chk("nextPc", p + 16'h0001, resOut.nextPc);
    issue(16'h7014, 16'h0000, 0);
    chk("class", oid_pkg::CL_SHIFT, decOut.cls);
    chk("regNum", 3'h7, decOut.regNum);
    chk("rotatePair", 0, resOut.rotatePair);
    issue(16'h7094, 16'h0000, 0);
    chk("rotatePair", 1, resOut.rotatePair);
    issue(16'h6094, 16'h0000, 0);
    chk("rotatePair", 0, resOut.rotatePair);
    issue(16'h8110, 16'($random(seed)), 0);
    chk("class", oid_pkg::CL_IO, decOut.cls);
    chk("ioWords", 1, n > 2 && n < 7);
    chk("nextPc", p + 16'(n), resOut.nextPc);
    chk("words", 4, n);
    issue(16'h5104, 16'h0000, 0);
    chk("class", oid_pkg::CL_BRREG, decOut.cls);
    chk("taken", regCondTrue, resOut.branchTaken);
    chk("target", p + 16'h0004, resOut.effAddr);
    chk("nextPc", p + 16'h0001, resOut.nextPc);
    ev = 16'($random(seed));
    issue(16'h5100, ev, 1);
    chk("target", p + ev, resOut.effAddr);
    chk("words", 2, n);
    chk("nextPc", p + 16'h0002, resOut.nextPc);
    issue(16'h0178, 16'h0000, 0);
    chk("class", oid_pkg::CL_BRIND, decOut.cls);
    chk("taken", indicatorTrue, resOut.branchTaken);
    chk("target", p - 16'h0008, resOut.effAddr);
    issue(16'h3185, 16'h0000, 0);
    chk("class", oid_pkg::CL_SVI, decOut.cls);
    chk("operand", 16'hff85, resOut.operand);
    chk("words", 1, n);
    summarize();
  end
endmodule

// file: verilog/operand_instruction_decode.sv
// Purpose: Decode operand instructions and form effective addresses
// Assumes: Register values are supplied by the datapath each cycle
// Notes: Syllable 7 bits: [6:4] kind, [3] indirect, [2:0] register
`include "oid_regs.svh"
module operand_instruction_decode (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic instValid,
  input wire logic [15:0] instWord,
  input wire logic extValid,
  input wire logic [15:0] extWord,
  input wire logic [15:0] pcIn,
  input wire logic [15:0] baseVal,
  input wire logic [15:0] indexVal,
  input wire logic [15:0] levelVectorBase,
  input wire logic regCondTrue,
  input wire logic indicatorTrue,
  output oid_pkg::oid_dec_s decOut,
  output oid_pkg::oid_res_s resOut,
  output logic resValid,
  output logic needExt
);
  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rstMeta;
  logic rstSync;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  function automatic oid_pkg::oid_mode_e syllMode(input logic [6:0] s);
    begin
      unique case (s[6:4])
        3'h0: syllMode = (s[2:0] == 3'h0) ? oid_pkg::AM_IMM
                                          : oid_pkg::AM_REG;
        3'h1: syllMode = (s[2:0] == 3'h0) ? oid_pkg::AM_ABS
                                          : oid_pkg::AM_BASE;
        3'h2: syllMode = oid_pkg::AM_PUSH;
        3'h3: syllMode = oid_pkg::AM_POP;
        3'h4: syllMode = oid_pkg::AM_AIX_DEC;
        3'h5: syllMode = oid_pkg::AM_AIX_INC;
        3'h6: syllMode = (s[2:0] == 3'h0) ? oid_pkg::AM_REL_P
                                          : oid_pkg::AM_REL_B;
        3'h7: syllMode = oid_pkg::AM_REL_IV;
      endcase
    end
  endfunction

  function automatic logic [2:0] modeLen(input oid_pkg::oid_mode_e m);
    begin
      unique case (m)
        oid_pkg::AM_IMM, oid_pkg::AM_ABS, oid_pkg::AM_REL_P,
        oid_pkg::AM_REL_B, oid_pkg::AM_REL_IV:
          modeLen = `OID_LEN_TWO;
        default: modeLen = `OID_LEN_ONE;
      endcase
    end
  endfunction

  logic [2:0] rn;
  logic [4:0] opc;
  logic [6:0] syl;
  oid_pkg::oid_mode_e mode;
  oid_pkg::oid_dec_s next_dec;
  assign rn = instWord[`OID_RN_HI:`OID_RN_LO];
  assign opc = instWord[`OID_OP_HI:`OID_OP_LO];
  assign syl = instWord[`OID_AS_HI:`OID_AS_LO];
  assign mode = syllMode(syl);

  always_comb begin
    next_dec = '0;
    next_dec.opcode = opc;
    next_dec.regNum = rn;
    next_dec.mode = oid_pkg::AM_NONE;
    next_dec.length = `OID_LEN_ONE;
    next_dec.baseReg = syl[2:0];
    next_dec.indexReg = syl[1:0];
    if (instWord[`OID_W_OPBIT]) begin
      next_dec.regIsAddr = rn != `OID_RN_ZERO &&
                           opc >= `OID_OP_ADDR_REG;
      if (rn == `OID_IO_SEL && opc == `OID_OP_IO_LOAD_OP) begin
        next_dec.cls = oid_pkg::CL_IO;
      end else if (opc[4:3] == `OID_OP_SCI_HI) begin
        next_dec.cls = oid_pkg::CL_SCI;
      end else if (rn == `OID_RN_ZERO) begin
        next_dec.cls = oid_pkg::CL_SINGLE;
      end else begin
        next_dec.cls = oid_pkg::CL_DOUBLE;
      end
      next_dec.mode = mode;
      next_dec.indirect = syl[3] && mode != oid_pkg::AM_REL_IV;
      next_dec.indexed = mode == oid_pkg::AM_AIX_DEC ||
                         mode == oid_pkg::AM_AIX_INC;
      next_dec.length = (next_dec.cls == oid_pkg::CL_IO) ?
          modeLen(mode) + `OID_LEN_TWO : modeLen(mode);
      if (next_dec.cls == oid_pkg::CL_SCI)
        next_dec.length = modeLen(mode);
    end else if (instWord[15:8] == `OID_TOP8_ZERO) begin
      next_dec.cls = oid_pkg::CL_GENERIC;
    end else if (instWord[11:8] == `OID_OPC_ZERO) begin
      next_dec.cls = oid_pkg::CL_SHIFT;
    end else if (instWord[7]) begin
      next_dec.cls = oid_pkg::CL_SVI;
    end else if (rn == `OID_RN_ZERO) begin
      next_dec.cls = oid_pkg::CL_BRIND;
      next_dec.length = (instWord[6:0] == 7'h00) ? `OID_LEN_TWO
                                                 : `OID_LEN_ONE;
    end else begin
      next_dec.cls = oid_pkg::CL_BRREG;
      next_dec.length = (instWord[6:0] == 7'h00) ? `OID_LEN_TWO
                                                 : `OID_LEN_ONE;
    end
  end

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  oid_pkg::oid_state_e state;
  logic [15:0] inst;
  logic [2:0] extLeft;
  logic [15:0] ext1;
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      state <= oid_pkg::ST_IDLE;
      decOut <= '0;
      inst <= 16'h0000;
      extLeft <= 3'h0;
      ext1 <= 16'h0000;
      needExt <= 1'b0;
    end else if (clkEn) begin
      unique case (state)
        oid_pkg::ST_IDLE: begin
          if (instValid) begin
            decOut <= next_dec;
            inst <= instWord;
            if (next_dec.length > `OID_LEN_ONE) begin
              state <= oid_pkg::ST_EXT;
              extLeft <= next_dec.length - `OID_LEN_ONE;
              needExt <= 1'b1;
            end
          end
        end
        oid_pkg::ST_EXT: begin
          if (extValid) begin
            if (extLeft == decOut.length - `OID_LEN_ONE)
              ext1 <= extWord;
            extLeft <= extLeft - 3'h1;
            if (extLeft == 3'h1) begin
              state <= oid_pkg::ST_IDLE;
              needExt <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  logic finish;
  logic [15:0] firstExt;
  assign finish = (state == oid_pkg::ST_IDLE && instValid &&
                   next_dec.length == `OID_LEN_ONE) ||
                  (state == oid_pkg::ST_EXT && extValid &&
                   extLeft == 3'h1);
  assign firstExt = (state == oid_pkg::ST_EXT &&
                     extLeft == decOut.length - `OID_LEN_ONE) ?
                    extWord : ext1;

  // ----------------------------------------
  // Effective address and results
  // ----------------------------------------
  oid_pkg::oid_dec_s d;
  logic [15:0] w;
  logic [15:0] step;
  oid_pkg::oid_res_s next_res;
  assign d = (state == oid_pkg::ST_IDLE) ? next_dec : decOut;
  assign w = (state == oid_pkg::ST_IDLE) ? instWord : inst;
  assign step = (d.opcode == `OID_OP_DBLWORD) ? `OID_STEP_TWO
                                              : `OID_STEP_ONE;

  always_comb begin
    next_res = '0;
    next_res.nextPc = pcIn + {13'h0000, d.length};
    unique case (d.mode)
      oid_pkg::AM_IMM: next_res.operand = firstExt;
      oid_pkg::AM_ABS: next_res.effAddr = firstExt;
      oid_pkg::AM_BASE: next_res.effAddr = baseVal;
      oid_pkg::AM_PUSH: begin
        next_res.effAddr = baseVal - step;
        next_res.newBase = baseVal - step;
        next_res.writeBase = 1'b1;
      end
      oid_pkg::AM_POP: begin
        next_res.effAddr = baseVal;
        next_res.newBase = baseVal + step;
        next_res.writeBase = 1'b1;
      end
      oid_pkg::AM_AIX_DEC: begin
        next_res.newIndex = indexVal - `OID_STEP_ONE;
        next_res.effAddr = baseVal + next_res.newIndex;
        next_res.writeIndex = 1'b1;
      end
      oid_pkg::AM_AIX_INC: begin
        next_res.effAddr = baseVal + indexVal;
        next_res.newIndex = indexVal + `OID_STEP_ONE;
        next_res.writeIndex = 1'b1;
      end
      oid_pkg::AM_REL_P: next_res.effAddr = pcIn + firstExt;
      oid_pkg::AM_REL_B: next_res.effAddr = baseVal + firstExt;
      oid_pkg::AM_REL_IV:
        next_res.effAddr = levelVectorBase + firstExt;
      default: next_res.effAddr = 16'h0000;
    endcase
    unique case (d.cls)
      oid_pkg::CL_SINGLE:
        next_res.clearTarget = d.opcode == `OID_OP_CLEAR;
      oid_pkg::CL_DOUBLE:
        next_res.addToReg = d.opcode == `OID_OP_ADD;
      oid_pkg::CL_BRREG: begin
        next_res.branchTaken = regCondTrue;
        next_res.effAddr = (d.length == `OID_LEN_TWO) ?
            pcIn + firstExt : pcIn + {{9{w[6]}}, w[6:0]};
      end
      oid_pkg::CL_BRIND: begin
        next_res.branchTaken = indicatorTrue;
        next_res.effAddr = (d.length == `OID_LEN_TWO) ?
            pcIn + firstExt : pcIn + {{9{w[6]}}, w[6:0]};
      end
      oid_pkg::CL_SVI:
        next_res.operand = {{8{w[7]}}, w[7:0]};
      oid_pkg::CL_SHIFT:
        next_res.rotatePair = w[6:4] == `OID_SHF_ROTL &&
                              w[`OID_DBL_BIT] &&
                              d.regNum[0];
      oid_pkg::CL_GENERIC:
        if (w[7:0] == `OID_FN_MCALL)
          next_res.trapVector = `OID_TRAP_MCALL;
      oid_pkg::CL_SCI: next_res.trapVector = `OID_TRAP_SCI;
      default: next_res.trapVector = `OID_TRAP_NONE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      resOut <= '0;
      resValid <= 1'b0;
    end else if (clkEn) begin
      resValid <= finish;
      if (finish)
        resOut <= next_res;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reg_len: assert property (@(posedge core_clk) disable iff (!rstSync)
    clkEn && instValid && state == oid_pkg::ST_IDLE &&
    next_dec.cls == oid_pkg::CL_DOUBLE && mode == oid_pkg::AM_REG
    |-> next_dec.length == `OID_LEN_ONE)
    else $error("register mode not one word");
  a_imm_pc: assert property (@(posedge core_clk) disable iff (!rstSync)
    finish && clkEn && d.mode == oid_pkg::AM_IMM &&
    d.cls != oid_pkg::CL_IO |=> resOut.nextPc == $past(pcIn) + `OID_STEP_TWO)
    else $error("immediate pc not plus two");
  a_push_dec: assert property (@(posedge core_clk) disable iff (!rstSync)
    finish && clkEn && d.mode == oid_pkg::AM_PUSH
    |=> resOut.newBase == $past(baseVal) - $past(step))
    else $error("push not predecremented");
  a_pop_inc: assert property (@(posedge core_clk) disable iff (!rstSync)
    finish && clkEn && d.mode == oid_pkg::AM_POP
    |=> resOut.effAddr == $past(baseVal))
    else $error("pop used adjusted base");
  a_iv_direct: assert property (@(posedge core_clk) disable iff (!rstSync)
    decOut.mode == oid_pkg::AM_REL_IV |-> !decOut.indirect)
    else $error("vector relative indirect");
  a_sci_trap: assert property (@(posedge core_clk) disable iff (!rstSync)
    resValid && resOut.trapVector == `OID_TRAP_SCI
    |-> decOut.cls == oid_pkg::CL_SCI)
    else $error("scientific trap mismatch");
  a_ext_done: assert property (@(posedge core_clk) disable iff (!rstSync)
    state == oid_pkg::ST_EXT && clkEn && extValid && extLeft == 3'h1
    |=> state == oid_pkg::ST_IDLE && resValid)
    else $error("extension sequence stuck");
  a_io_len: assert property (@(posedge core_clk) disable iff (!rstSync)
    decOut.cls == oid_pkg::CL_IO |-> decOut.length >= `OID_LEN_IOMIN &&
    decOut.length <= `OID_LEN_IOMAX)
    else $error("io length out of range");
  a_svi_len: assert property (
    @(posedge core_clk) disable iff (!rstSync)
    clkEn && instValid && state == oid_pkg::ST_IDLE &&
    next_dec.cls == oid_pkg::CL_SVI |-> next_dec.length == `OID_LEN_ONE)
    else $error("short value not one word");
  a_brind_reg: assert property (
    @(posedge core_clk) disable iff (!rstSync)
    resValid && decOut.cls == oid_pkg::CL_BRIND
    |-> decOut.regNum == `OID_RN_ZERO)
    else $error("indicator branch with register");
  a_rot_odd: assert property (
    @(posedge core_clk) disable iff (!rstSync)
    resValid && resOut.rotatePair |-> decOut.regNum[0])
    else $error("pair rotate on even register");
  c_io: cover property (@(posedge core_clk) disable iff (!rstSync)
    resValid && decOut.cls == oid_pkg::CL_IO);
  c_rotate: cover property (@(posedge core_clk) disable iff (!rstSync)
    resValid && resOut.rotatePair);
  c_push: cover property (@(posedge core_clk) disable iff (!rstSync)
    resValid && resOut.writeBase);
  c_branch: cover property (@(posedge core_clk) disable iff (!rstSync)
    resValid && resOut.branchTaken);
  c_ext: cover property (@(posedge core_clk) disable iff (!rstSync)
    state == oid_pkg::ST_EXT ##1 resValid);
endmodule
